// File: logic/fp_load_decode.sv
// Decode and execution control for float doubleword and quad loads
// Assumes register files and memory load path share core_clk; memory answers with mem_rsp_valid
`timescale 1ns/10ps
`include "fp_load_defines.svh"
module fp_load_decode
    import fp_load_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    output logic instr_ready,
    output logic instr_illegal,
    // Integer register read
    output logic [4:0] int_rd_a_addr,
    input wire logic [31:0] int_rd_a_data,
    output logic [4:0] int_rd_b_addr,
    input wire logic [31:0] int_rd_b_data,
    // Memory load path
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_rsp_valid,
    input wire logic [63:0] mem_rsp_data,
    input wire logic mem_align_fault,
    input wire logic mem_storage_fault,
    // Float register write
    output logic float_wr_en,
    output logic [4:0] float_wr_addr,
    output logic [63:0] float_wr_data,
    // Integer base update
    output logic int_wr_en,
    output logic [4:0] int_wr_addr,
    output logic [31:0] int_wr_data,
    // Status and condition writes, always idle
    output logic fpscr_wr_en,
    output logic cr0_wr_en,
    // Completion
    output logic done,
    output logic fault
);
    ////////////////////////////////////////////////////////////////////////
    load_kind_t kind;
    logic [4:0] tgt_dec, base_dec, idx_dec;
    logic [31:0] disp_sext, quad_offset;
    fp_load_field_decode u_dec (
        .instr(instr),
        .kind(kind),
        .float_target_field(tgt_dec),
        .base_reg_field(base_dec),
        .index_reg_field(idx_dec),
        .disp_sext(disp_sext),
        .quad_offset(quad_offset)
    );
    ////////////////////////////////////////////////////////////////////////
    load_state_t state_ff;
    load_kind_t kind_ff;
    logic [4:0] tgt_ff, base_ff;
    logic [31:0] effective_addr;
    logic [31:0] addr_ff;
    logic fault_ff;
    logic is_upd, is_quad, take;
    logic [31:0] base_val, operand;
    logic [4:0] second_tgt;
    assign int_rd_a_addr = base_dec;
    assign int_rd_b_addr = idx_dec;
    assign instr_ready = (state_ff == ST_IDLE);
    assign take = instr_valid && instr_ready && kind != LD_NONE;
    assign instr_illegal = instr_valid && instr_ready && kind == LD_NONE;
    assign base_val = (base_dec != 5'h00) ? int_rd_a_data : 32'h00000000;
    always_comb begin
        case (kind)
            LD_DWORD_IDX_UPD, LD_DWORD_IDX: operand = int_rd_b_data;
            LD_QUAD, LD_QUAD_UPD: operand = quad_offset;
            default: operand = disp_sext;
        endcase
    end
    assign effective_addr = base_val + operand;
    assign is_upd = kind_ff == LD_DWORD_UPD || kind_ff == LD_DWORD_IDX_UPD || kind_ff == LD_QUAD_UPD;
    assign is_quad = kind_ff == LD_QUAD || kind_ff == LD_QUAD_UPD;
    assign second_tgt = (tgt_ff == `LAST_FLOAT_REG) ? 5'h00 : tgt_ff + 5'h01;
    assign mem_req = state_ff != ST_IDLE;
    assign mem_addr = (state_ff == ST_WAIT_SECOND) ? addr_ff + `QUAD_SECOND_OFFSET : addr_ff;
    assign fpscr_wr_en = 1'b0;
    assign cr0_wr_en = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: if (take) state_ff <= ST_WAIT_FIRST;
                ST_WAIT_FIRST: begin
                    if (mem_rsp_valid) begin
                        if (mem_align_fault || mem_storage_fault || !is_quad) state_ff <= ST_IDLE;
                        else state_ff <= ST_WAIT_SECOND;
                    end
                end
                ST_WAIT_SECOND: if (mem_rsp_valid) state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
    // Captured instruction
    always_ff @(posedge core_clk) begin
        if (rst) begin
            kind_ff <= LD_NONE;
            tgt_ff <= 5'h00;
            base_ff <= 5'h00;
            addr_ff <= 32'h00000000;
        end else if (take) begin
            kind_ff <= kind;
            tgt_ff <= tgt_dec;
            base_ff <= base_dec;
            addr_ff <= effective_addr;
        end
    end
    // Fault tracking
    always_ff @(posedge core_clk) begin
        if (rst || take) begin
            fault_ff <= 1'b0;
        end else if (mem_rsp_valid && state_ff != ST_IDLE && (mem_align_fault || mem_storage_fault)) begin
            fault_ff <= 1'b1;
        end
    end
    // Float register write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            float_wr_en <= 1'b0;
            float_wr_addr <= 5'h00;
            float_wr_data <= 64'h0;
        end else begin
            float_wr_en <= mem_rsp_valid && state_ff != ST_IDLE && !mem_align_fault && !mem_storage_fault;
            float_wr_addr <= (state_ff == ST_WAIT_SECOND) ? second_tgt : tgt_ff;
            float_wr_data <= mem_rsp_data;
        end
    end
    // Base update and completion
    logic last_ok, last_any;
    assign last_any = mem_rsp_valid && ((state_ff == ST_WAIT_FIRST && (!is_quad || mem_align_fault
        || mem_storage_fault)) || state_ff == ST_WAIT_SECOND);
    assign last_ok = last_any && !mem_align_fault && !mem_storage_fault && !fault_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_wr_en <= 1'b0;
            int_wr_addr <= 5'h00;
            int_wr_data <= 32'h00000000;
            done <= 1'b0;
            fault <= 1'b0;
        end else begin
            int_wr_en <= last_ok && is_upd && base_ff != 5'h00;
            int_wr_addr <= base_ff;
            int_wr_data <= addr_ff;
            done <= last_any;
            fault <= last_any && !last_ok;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Base register update
    a_no_update_idx: assert property (@(posedge core_clk) disable iff (rst)
        (last_any && kind_ff == LD_DWORD_IDX) |=> !int_wr_en) else $error("indexed load wrote base");
    a_update_needs_ok: assert property (@(posedge core_clk) disable iff (rst)
        int_wr_en |-> $past(last_ok) && int_wr_addr != 5'h00 && done) else $error("bad base update");
    a_update_on_ok: assert property (@(posedge core_clk) disable iff (rst)
        (last_ok && is_upd && base_ff != 5'h00) |=> int_wr_en && int_wr_data == $past(addr_ff))
        else $error("missing base update");
    a_fault_no_write: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff != ST_IDLE && mem_rsp_valid && (mem_align_fault || mem_storage_fault))
        |=> !float_wr_en && !int_wr_en && done && fault) else $error("faulting access wrote");
    // Float register steering
    a_dword_target: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff == ST_WAIT_FIRST && mem_rsp_valid && !mem_align_fault && !mem_storage_fault)
        |=> float_wr_en && float_wr_addr == $past(tgt_ff)) else $error("first target wrong");
    a_quad_wrap: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff == ST_WAIT_SECOND && mem_rsp_valid && tgt_ff == 5'h1f && !mem_align_fault && !mem_storage_fault)
        |=> float_wr_en && float_wr_addr == 5'h00) else $error("quad wrap wrong");
    a_quad_next_reg: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff == ST_WAIT_SECOND && mem_rsp_valid && tgt_ff != 5'h1f && !mem_align_fault && !mem_storage_fault)
        |=> float_wr_en && float_wr_addr == $past(tgt_ff) + 5'h01) else $error("quad next register wrong");
    a_quad_second_addr: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == ST_WAIT_SECOND |-> mem_addr == addr_ff + 32'h8) else $error("second address wrong");
    a_first_addr: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == ST_WAIT_FIRST |-> mem_addr == addr_ff) else $error("first address wrong");
    a_data_passthru: assert property (@(posedge core_clk) disable iff (rst)
        float_wr_en |-> float_wr_data == $past(mem_rsp_data)) else $error("data altered");
    a_status_idle: assert property (@(posedge core_clk) disable iff (rst)
        !fpscr_wr_en && !cr0_wr_en) else $error("status written");
    // Address formation at capture
    a_addr_base_zero: assert property (@(posedge core_clk) disable iff (rst)
        (take && kind == LD_DWORD_UPD && base_dec == 5'h00) |=> addr_ff == $past(disp_sext))
        else $error("address with zero base wrong");
    a_addr_disp_base: assert property (@(posedge core_clk) disable iff (rst)
        (take && kind == LD_DWORD_UPD && base_dec != 5'h00) |=> addr_ff == $past(int_rd_a_data) + $past(disp_sext))
        else $error("displacement address wrong");
    a_addr_indexed: assert property (@(posedge core_clk) disable iff (rst)
        (take && kind == LD_DWORD_IDX && base_dec != 5'h00) |=> addr_ff == $past(int_rd_a_data) + $past(int_rd_b_data))
        else $error("indexed address wrong");
    a_addr_idx_zero: assert property (@(posedge core_clk) disable iff (rst)
        (take && (kind == LD_DWORD_IDX || kind == LD_DWORD_IDX_UPD) && base_dec == 5'h00)
        |=> addr_ff == $past(int_rd_b_data)) else $error("indexed zero base address wrong");
    a_addr_quad: assert property (@(posedge core_clk) disable iff (rst)
        (take && kind == LD_QUAD && base_dec == 5'h00) |=> addr_ff == $past(quad_offset)) else $error("quad offset");
    a_addr_quad_base: assert property (@(posedge core_clk) disable iff (rst)
        (take && (kind == LD_QUAD || kind == LD_QUAD_UPD) && base_dec != 5'h00)
        |=> addr_ff == $past(int_rd_a_data) + $past(quad_offset)) else $error("quad base address wrong");
    // Opcode recognition
    a_decode_disp: assert property (@(posedge core_clk) disable iff (rst)
        instr[31:26] == 6'h33 |-> kind == LD_DWORD_UPD) else $error("displacement load not decoded");
    a_decode_idx_upd: assert property (@(posedge core_clk) disable iff (rst)
        (instr[31:26] == 6'h1f && instr[10:1] == 10'h277) |-> kind == LD_DWORD_IDX_UPD)
        else $error("indexed update load not decoded");
    a_decode_idx: assert property (@(posedge core_clk) disable iff (rst)
        (instr[31:26] == 6'h1f && instr[10:1] == 10'h257) |-> kind == LD_DWORD_IDX)
        else $error("indexed load not decoded");
    a_decode_quad_bits: assert property (@(posedge core_clk) disable iff (rst)
        (instr[31:26] == 6'h38 && instr[1:0] != 2'b00) |-> kind == LD_NONE) else $error("bad quad word accepted");
    a_decode_quad_upd: assert property (@(posedge core_clk) disable iff (rst)
        (instr[31:26] == 6'h39 && instr[1:0] == 2'b00) |-> kind == LD_QUAD_UPD) else $error("quad update not decoded");
endmodule : fp_load_decode

// File: pkg/fp_load_defines.svh
// Encodings, last float register and quad second-access offset for the float load decoder
// Assumes instruction bits are numbered 31 (msb) to 0 (lsb), with the opcode in bits 31:26
`ifndef FP_LOAD_DEFINES_SVH
`define FP_LOAD_DEFINES_SVH
`define OP_DWORD_LOAD_UPDATE 6'h33
`define OP_INDEXED_GROUP 6'h1f
`define XOP_DWORD_INDEXED_UPDATE 10'h277
`define XOP_DWORD_INDEXED 10'h257
`define OP_QUAD_LOAD 6'h38
`define OP_QUAD_LOAD_UPDATE 6'h39
`define QUAD_LOW_BITS 2'h0
`define LAST_FLOAT_REG 5'h1f
`define QUAD_SECOND_OFFSET 32'h00000008
`endif

// File: pkg/fp_load_pkg.sv
// Types shared by the float load decoder files
// Assumes fp_load_defines.svh is compiled alongside
package fp_load_pkg;
    typedef enum logic [2:0] {
        LD_NONE, LD_DWORD_UPD, LD_DWORD_IDX_UPD, LD_DWORD_IDX, LD_QUAD, LD_QUAD_UPD
    } load_kind_t;
    typedef enum {
        ST_IDLE, ST_WAIT_FIRST, ST_WAIT_SECOND
    } load_state_t;
endpackage : fp_load_pkg

// File: logic/fp_load_field_decode.sv
// Combinational field extraction and opcode match for one instruction word
// Assumes the word is stable while instr_valid is high
`timescale 1ns/10ps
`include "fp_load_defines.svh"
module fp_load_field_decode
    import fp_load_pkg::*;
(
    // Instruction
    input wire logic [31:0] instr,
    // Decoded fields
    output load_kind_t kind,
    output logic [4:0] float_target_field,
    output logic [4:0] base_reg_field,
    output logic [4:0] index_reg_field,
    output logic [31:0] disp_sext,
    output logic [31:0] quad_offset
);
    logic [5:0] opcode;
    logic [9:0] xop;
    logic [13:0] word_displacement_field;
    assign opcode = instr[31:26];
    assign float_target_field = instr[25:21];
    assign base_reg_field = instr[20:16];
    assign index_reg_field = instr[15:11];
    assign xop = instr[10:1];
    assign word_displacement_field = instr[15:2];
    assign disp_sext = {{16{instr[15]}}, instr[15:0]};
    assign quad_offset = {{16{word_displacement_field[13]}}, word_displacement_field, 2'b00};
    always_comb begin
        kind = LD_NONE;
        if (opcode == `OP_DWORD_LOAD_UPDATE) begin
            kind = LD_DWORD_UPD;
        end else if (opcode == `OP_INDEXED_GROUP && xop == `XOP_DWORD_INDEXED_UPDATE) begin
            kind = LD_DWORD_IDX_UPD;
        end else if (opcode == `OP_INDEXED_GROUP && xop == `XOP_DWORD_INDEXED) begin
            kind = LD_DWORD_IDX;
        end else if (opcode == `OP_QUAD_LOAD && instr[1:0] == `QUAD_LOW_BITS) begin
            kind = LD_QUAD;
        end else if (opcode == `OP_QUAD_LOAD_UPDATE && instr[1:0] == `QUAD_LOW_BITS) begin
            kind = LD_QUAD_UPD;
        end
    end
endmodule : fp_load_field_decode

// File: bench/fp_load_far_side.sv
// Behavioural integer register file and memory load path for the decoder
// Assumes one clock; latency and fault choice are set by the bench
`timescale 1ns/10ps
module fp_load_far_side (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench control
    input wire logic [3:0] lat,
    input wire logic [1:0] flt,
    // Integer register read
    input wire logic [4:0] int_rd_a_addr,
    output logic [31:0] int_rd_a_data,
    input wire logic [4:0] int_rd_b_addr,
    output logic [31:0] int_rd_b_data,
    // Memory load path
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_rsp_valid,
    output logic [63:0] mem_rsp_data,
    output logic mem_align_fault,
    output logic mem_storage_fault
);
    logic [3:0] wait_ff;
    assign int_rd_a_data = 32'h10000000 + {19'h0, int_rd_a_addr, 8'h00};
    assign int_rd_b_data = 32'h10000000 + {19'h0, int_rd_b_addr, 8'h00};
    assign mem_rsp_valid = mem_req && (wait_ff == lat);
    // Data carries its own address; scrambled while no answer stands
    assign mem_rsp_data = mem_rsp_valid ? {~mem_addr, mem_addr} : {mem_addr, ~mem_addr};
    assign mem_align_fault = mem_rsp_valid & flt[0];
    assign mem_storage_fault = mem_rsp_valid & flt[1];
    always_ff @(posedge core_clk) begin
        if (rst || !mem_req || mem_rsp_valid) begin
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule : fp_load_far_side

// File: bench/fp_double_quad_load_decode_bench.sv
// Self-checking bench for the float load decoder
// Assumes fp_load_far_side models register file and memory
`timescale 1ns/10ps
`include "fp_load_defines.svh"
module fp_double_quad_load_decode_bench;
    import fp_load_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [3:0] lat = 4'h0;
    logic [1:0] flt = 2'h0;
    wire logic instr_ready, instr_illegal, mem_req, mem_rsp_valid, mem_align_fault, mem_storage_fault;
    wire logic float_wr_en, int_wr_en, fpscr_wr_en, cr0_wr_en, done, fault;
    wire logic [4:0] int_rd_a_addr, int_rd_b_addr, float_wr_addr, int_wr_addr;
    wire logic [31:0] int_rd_a_data, int_rd_b_data, mem_addr, int_wr_data;
    wire logic [63:0] mem_rsp_data, float_wr_data;
    int errors = 0, tests_run = 0, nf = 0, ni = 0;
    logic [4:0] fa [2];
    logic [63:0] fd [2];
    logic [4:0] ia;
    logic [31:0] idat;
    logic fault_seen;
    fp_load_decode u_fp_load_decode (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .instr_illegal(instr_illegal), .int_rd_a_addr(int_rd_a_addr),
        .int_rd_a_data(int_rd_a_data), .int_rd_b_addr(int_rd_b_addr), .int_rd_b_data(int_rd_b_data),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .mem_align_fault(mem_align_fault), .mem_storage_fault(mem_storage_fault), .float_wr_en(float_wr_en),
        .float_wr_addr(float_wr_addr), .float_wr_data(float_wr_data), .int_wr_en(int_wr_en),
        .int_wr_addr(int_wr_addr), .int_wr_data(int_wr_data), .fpscr_wr_en(fpscr_wr_en),
        .cr0_wr_en(cr0_wr_en), .done(done), .fault(fault));
    fp_load_far_side u_fp_load_far_side (.core_clk(core_clk), .rst(rst), .lat(lat), .flt(flt),
        .int_rd_a_addr(int_rd_a_addr), .int_rd_a_data(int_rd_a_data), .int_rd_b_addr(int_rd_b_addr),
        .int_rd_b_data(int_rd_b_data), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data), .mem_align_fault(mem_align_fault), .mem_storage_fault(mem_storage_fault));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : chk
    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // Records writes in the cycle they stand
    always @(negedge core_clk) begin
        chk("status write", 64'h0, {62'h0, fpscr_wr_en, cr0_wr_en});
        if (float_wr_en === 1'b1) begin
            if (nf < 2) begin
                fa[nf] = float_wr_addr;
                fd[nf] = float_wr_data;
            end
            nf++;
        end
        if (int_wr_en === 1'b1) begin
            ia = int_wr_addr;
            idat = int_wr_data;
            ni++;
        end
        if (done === 1'b1) fault_seen = fault;
    end
    ////////////////////////////////////////////////////////////////////////
    // Offers one word and waits for its completion pulse
    task automatic issue(input logic [31:0] word, input logic [3:0] l, input logic [1:0] f);
        int n;
        n = 0;
        nf = 0;
        ni = 0;
        fault_seen = 1'bx;
        lat = l;
        flt = f;
        instr = word;
        instr_valid = 1'b1;
        @(negedge core_clk);
        instr_valid = 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 40) chk("done timeout", 64'h1, 64'h0);
        @(negedge core_clk);
    endtask : issue
    task automatic verify(input logic [4:0] t0, input logic [31:0] ea, input int nf_exp, input int ni_exp,
        input logic [4:0] ia_exp, input logic flt_exp);
        logic [31:0] ea2;
        logic [4:0] t1;
        ea2 = ea + 32'h00000008;
        t1 = t0 + 5'h01;
        chk("float write count", nf_exp, nf);
        chk("fault flag", {63'h0, flt_exp}, {63'h0, fault_seen});
        chk("base write count", ni_exp, ni);
        if (nf_exp > 0) chk("first target", t0, fa[0]);
        if (nf_exp > 0) chk("first data", {~ea, ea}, fd[0]);
        if (nf_exp > 1) chk("second target", t1, fa[1]);
        if (nf_exp > 1) chk("second data", {~ea2, ea2}, fd[1]);
        if (ni_exp > 0) chk("base target", ia_exp, ia);
        if (ni_exp > 0) chk("base data", ea, idat);
    endtask : verify
    task automatic refuse(input logic [31:0] word);
        instr = word;
        instr_valid = 1'b1;
        #1;
        chk("illegal flag", 64'h1, instr_illegal);
        @(negedge core_clk);
        instr_valid = 1'b0;
        chk("request after illegal", 64'h0, mem_req);
        chk("ready after illegal", 64'h1, instr_ready);
    endtask : refuse
    ////////////////////////////////////////////////////////////////////////
    task automatic sc_dword_upd();
        issue({6'h33, 5'h06, 5'h05, 16'hfff8}, 4'h1, 2'h0);
        verify(5'h06, 32'h100004f8, 1, 1, 5'h05, 1'b0);
        issue({6'h33, 5'h07, 5'h00, 16'h0010}, 4'h2, 2'h0);
        verify(5'h07, 32'h00000010, 1, 0, 5'h00, 1'b0);
        issue({6'h33, 5'h08, 5'h00, 16'h8000}, 4'h0, 2'h0);
        verify(5'h08, 32'hffff8000, 1, 0, 5'h00, 1'b0);
    endtask : sc_dword_upd
    task automatic sc_dword_fault();
        issue({6'h33, 5'h06, 5'h05, 16'h0020}, 4'h0, 2'h1);
        verify(5'h06, 32'h10000520, 0, 0, 5'h05, 1'b1);
        issue({6'h33, 5'h06, 5'h05, 16'h0020}, 4'h3, 2'h2);
        verify(5'h06, 32'h10000520, 0, 0, 5'h05, 1'b1);
    endtask : sc_dword_fault
    task automatic sc_idx_upd();
        issue({6'h1f, 5'h03, 5'h07, 5'h09, 10'h277, 1'b0}, 4'h0, 2'h0);
        verify(5'h03, 32'h20001000, 1, 1, 5'h07, 1'b0);
        issue({6'h1f, 5'h03, 5'h00, 5'h09, 10'h277, 1'b1}, 4'h1, 2'h0);
        verify(5'h03, 32'h10000900, 1, 0, 5'h00, 1'b0);
    endtask : sc_idx_upd
    task automatic sc_idx();
        issue({6'h1f, 5'h0c, 5'h02, 5'h04, 10'h257, 1'b0}, 4'h1, 2'h0);
        verify(5'h0c, 32'h20000600, 1, 0, 5'h00, 1'b0);
        issue({6'h1f, 5'h0c, 5'h00, 5'h04, 10'h257, 1'b0}, 4'h0, 2'h0);
        verify(5'h0c, 32'h10000400, 1, 0, 5'h00, 1'b0);
    endtask : sc_idx
    task automatic sc_quad();
        issue({6'h38, 5'h1f, 5'h03, 14'h3fff, 2'h0}, 4'h0, 2'h0);
        verify(5'h1f, 32'h100002fc, 2, 0, 5'h00, 1'b0);
        issue({6'h38, 5'h04, 5'h00, 14'h0004, 2'h0}, 4'h2, 2'h0);
        verify(5'h04, 32'h00000010, 2, 0, 5'h00, 1'b0);
    endtask : sc_quad
    task automatic sc_quad_upd();
        issue({6'h39, 5'h0a, 5'h06, 14'h0002, 2'h0}, 4'h1, 2'h0);
        verify(5'h0a, 32'h10000608, 2, 1, 5'h06, 1'b0);
        issue({6'h39, 5'h0a, 5'h00, 14'h2000, 2'h0}, 4'h0, 2'h0);
        verify(5'h0a, 32'hffff8000, 2, 0, 5'h00, 1'b0);
        issue({6'h39, 5'h0a, 5'h06, 14'h0002, 2'h0}, 4'h0, 2'h2);
        verify(5'h0a, 32'h10000608, 0, 0, 5'h06, 1'b1);
    endtask : sc_quad_upd
    task automatic sc_illegal();
        refuse({6'h38, 5'h01, 5'h01, 14'h0000, 2'h1});
        refuse({6'h1f, 5'h01, 5'h01, 5'h01, 10'h317, 1'b0});
    endtask : sc_illegal
    task automatic sc_reset_mid();
        lat = 4'h6;
        flt = 2'h0;
        instr = {6'h39, 5'h02, 5'h03, 14'h0001, 2'h0};
        instr_valid = 1'b1;
        @(negedge core_clk);
        instr_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk("ready after reset", 64'h1, instr_ready);
        chk("request after reset", 64'h0, mem_req);
        chk("outputs after reset", 64'h0, {done, fault, float_wr_en, int_wr_en});
        issue({6'h38, 5'h02, 5'h03, 14'h0001, 2'h0}, 4'h0, 2'h0);
        verify(5'h02, 32'h10000304, 2, 0, 5'h00, 1'b0);
    endtask : sc_reset_mid
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #80000;
        chk("watchdog", 64'h0, 64'h1);
        give_verdict();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        sc_dword_upd();
        sc_dword_fault();
        sc_idx_upd();
        sc_idx();
        sc_quad();
        sc_quad_upd();
        sc_illegal();
        sc_reset_mid();
        give_verdict();
    end
endmodule : fp_double_quad_load_decode_bench
